// File: pcs_regs.vh
// Constants for the loop configuration register block.
// Included by the design, its checker and the bench; values are register
// indices, the byte address on APB is four times the index.
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define PCS_ADDR_W        18
`define PCS_IDX_W         16
`define PCS_REG_W         16
`define PCS_NREGS         6
`define PCS_ADDR_LSB      2

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define PCS_IDX_MULT      16'hf000
`define PCS_IDX_PRESCALE  16'hf001
`define PCS_IDX_SOURCE    16'hf002
`define PCS_IDX_ENABLE    16'hf003
`define PCS_IDX_LOCK      16'hf004
`define PCS_IDX_IRQ_STAT  16'hf010
`define PCS_IDX_IRQ_MASK  16'hf011

// ----------------------------------------------------------------
// Select positions from the address decoder
// ----------------------------------------------------------------
`define PCS_SEL_MULT      0
`define PCS_SEL_PRESCALE  1
`define PCS_SEL_SOURCE    2
`define PCS_SEL_ENABLE    3
`define PCS_SEL_LOCK      4
`define PCS_SEL_IRQ_STAT  5
`define PCS_SEL_IRQ_MASK  6
`define PCS_SEL_W         7

// ----------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------
`define PCS_MULT_W        7
`define PCS_PRE_W         2
`define PCS_MULT_RST      7'h60
`define PCS_PRE_RST       2'h0
`define PCS_SRC_RST       1'b0
`define PCS_DIV_W         4
`define PCS_DIV_RST       4'h1
`define PCS_FLAG_BIT      0

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define PCS_IRQ_W         3
`define PCS_IRQ_APPLIED   0
`define PCS_IRQ_LOCKED    1
`define PCS_IRQ_LOST      2

`endif

// File: pcs_top.v
// Staged configuration registers for the system clock loop, APB slave.
// Assumes one clock pclk; the lock indication arrives asynchronously from
// the analog loop, which itself lies outside this block.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.vh"

module pcs_top (
  // APB slave
  input  wire                        pclk,
  input  wire                        presetn,
  input  wire                        psel,
  input  wire                        penable,
  input  wire                        pwrite,
  input  wire [`PCS_ADDR_W-1:0]      paddr,
  input  wire [31:0]                 pwdata,
  output wire [31:0]                 prdata,
  output wire                        pready,
  output wire                        pslverr,
  // Analog loop
  input  wire                        loop_lock_pin,
  output wire                        loop_run,
  output wire [`PCS_MULT_W-1:0]      loop_multiplier,
  output wire [`PCS_PRE_W-1:0]       loop_prescale,
  output wire [`PCS_DIV_W-1:0]       loop_divide_onehot,
  // Core clock routing
  output wire                        active_source_select_bit,
  // Interrupt
  output wire                        irq
);

  // ----------------------------------------------------------------
  // Loop sequencing states
  // ----------------------------------------------------------------
  // An illegal code falls back to OFF through the default branch
  localparam [3:0] ST_OFF   = 4'b0001;
  localparam [3:0] ST_APPLY = 4'b0010;
  localparam [3:0] ST_WAIT  = 4'b0100;
  localparam [3:0] ST_LOCK  = 4'b1000;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // One-hot register select; all zero for an unmapped index
  function [`PCS_SEL_W-1:0] reg_sel;
    input [`PCS_IDX_W-1:0] idx;
    begin
      reg_sel = {`PCS_SEL_W{1'b0}};
      case (idx)
        `PCS_IDX_MULT:     reg_sel[`PCS_SEL_MULT]     = 1'b1;
        `PCS_IDX_PRESCALE: reg_sel[`PCS_SEL_PRESCALE] = 1'b1;
        `PCS_IDX_SOURCE:   reg_sel[`PCS_SEL_SOURCE]   = 1'b1;
        `PCS_IDX_ENABLE:   reg_sel[`PCS_SEL_ENABLE]   = 1'b1;
        `PCS_IDX_LOCK:     reg_sel[`PCS_SEL_LOCK]     = 1'b1;
        `PCS_IDX_IRQ_STAT: reg_sel[`PCS_SEL_IRQ_STAT] = 1'b1;
        `PCS_IDX_IRQ_MASK: reg_sel[`PCS_SEL_IRQ_MASK] = 1'b1;
        default:           reg_sel = {`PCS_SEL_W{1'b0}};
      endcase
    end
  endfunction

  // Prescaler code to divide ratio 1, 2, 4 or 8 as a one-hot vector
  function [`PCS_DIV_W-1:0] div_decode;
    input [`PCS_PRE_W-1:0] code;
    begin
      div_decode = {{(`PCS_DIV_W-1){1'b0}}, 1'b1} << code;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Staged copies answer reads; applied copies drive the loop outputs
  reg  [31:0]             prdata_q,  prdata_d;
  reg                     pready_q,  pready_d;
  reg                     pslverr_q, pslverr_d;
  reg  [`PCS_MULT_W-1:0]  mult_stage_q, mult_stage_d;
  reg  [`PCS_PRE_W-1:0]   pre_stage_q,  pre_stage_d;
  reg                     src_stage_q,  src_stage_d;
  reg  [`PCS_MULT_W-1:0]  mult_act_q,   mult_act_d;
  reg  [`PCS_PRE_W-1:0]   pre_act_q,    pre_act_d;
  reg                     src_act_q,    src_act_d;
  reg  [`PCS_DIV_W-1:0]   div_act_q,    div_act_d;
  reg                     enable_q,     enable_d;
  reg  [3:0]              state_q,      state_d;
  reg                     lock_flag_q,  lock_flag_d;
  reg  [`PCS_IRQ_W-1:0]   stat_q,       stat_d;
  reg  [`PCS_IRQ_W-1:0]   mask_q,       mask_d;
  reg  [`PCS_IRQ_W-1:0]   stat_rd_q,    stat_rd_d;
  reg                     irq_q,        irq_d;
  reg                     lock_s1_q;
  reg                     lock_s2_q;
  reg                     lock_s3_q;
  reg                     lock_filt_q,  lock_filt_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [`PCS_IDX_W-1:0] idx     = paddr[`PCS_ADDR_W-1:`PCS_ADDR_LSB];
  wire                  aligned = (paddr[`PCS_ADDR_LSB-1:0] ==
                                   {`PCS_ADDR_LSB{1'b0}});
  wire [`PCS_SEL_W-1:0] sel     = aligned ? reg_sel(idx)
                                          : {`PCS_SEL_W{1'b0}};
  wire                  setup   = psel & ~penable;
  wire                  done    = psel & penable & pready_q;
  wire                  wr_ok   = done & pwrite & ~pslverr_q;
  wire                  rd_ok   = done & ~pwrite & ~pslverr_q;
  // The lock register is read-only; a write to it is refused. Status
  // writes are ignored without error, so a blanket clear stays harmless.
  wire                  bad     = (sel == {`PCS_SEL_W{1'b0}}) |
                                  (pwrite & sel[`PCS_SEL_LOCK]);
  // Status reads clear only the bits that they returned
  wire                  stat_clr = rd_ok & sel[`PCS_SEL_IRQ_STAT];

  // A rising enable write marks the moment staged values go live.
  // Writing 1 while running applies nothing: retuning needs a disable
  // first, which also stops the loop.
  wire enable_rise = wr_ok & sel[`PCS_SEL_ENABLE] &
                     pwdata[`PCS_FLAG_BIT] & ~enable_q;

  // ----------------------------------------------------------------
  // Lock input synchroniser
  // ----------------------------------------------------------------
  // Three stages; a change is taken only once stages two and three agree,
  // which also rejects a single-cycle glitch from the analog side.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      lock_s3_q <= 1'b0;
    end else begin
      lock_s1_q <= loop_lock_pin;
      lock_s2_q <= lock_s1_q;
      lock_s3_q <= lock_s2_q;
    end
  end

  always @* begin
    lock_filt_d = lock_filt_q;
    if (lock_s2_q == lock_s3_q) begin
      lock_filt_d = lock_s3_q;
    end
  end

  // ----------------------------------------------------------------
  // APB register access
  // ----------------------------------------------------------------
  always @* begin
    pready_d     = 1'b0;
    pslverr_d    = pslverr_q;
    prdata_d     = prdata_q;
    stat_rd_d    = stat_rd_q;
    mult_stage_d = mult_stage_q;
    pre_stage_d  = pre_stage_q;
    src_stage_d  = src_stage_q;
    enable_d     = enable_q;
    mask_d       = mask_q;
    // Answer is prepared in the setup cycle so every bus output is a flop
    if (setup) begin
      pready_d  = 1'b1;
      pslverr_d = bad;
      prdata_d  = 32'h0000_0000;
      stat_rd_d = {`PCS_IRQ_W{1'b0}};
      if (!pwrite) begin
        if (sel[`PCS_SEL_MULT]) begin
          prdata_d[`PCS_MULT_W-1:0] = mult_stage_q;
        end
        if (sel[`PCS_SEL_PRESCALE]) begin
          prdata_d[`PCS_PRE_W-1:0] = pre_stage_q;
        end
        if (sel[`PCS_SEL_SOURCE]) begin
          prdata_d[`PCS_FLAG_BIT] = src_stage_q;
        end
        if (sel[`PCS_SEL_ENABLE]) begin
          prdata_d[`PCS_FLAG_BIT] = enable_q;
        end
        if (sel[`PCS_SEL_LOCK]) begin
          prdata_d[`PCS_FLAG_BIT] = lock_flag_q;
        end
        if (sel[`PCS_SEL_IRQ_STAT]) begin
          prdata_d[`PCS_IRQ_W-1:0] = stat_q;
          stat_rd_d = stat_q;
        end
        if (sel[`PCS_SEL_IRQ_MASK]) begin
          prdata_d[`PCS_IRQ_W-1:0] = mask_q;
        end
      end
    end else if (done) begin
      pslverr_d = 1'b0;
    end
    // Writes land at the completion edge, never in the setup cycle
    if (wr_ok) begin
      if (sel[`PCS_SEL_MULT]) begin
        mult_stage_d = pwdata[`PCS_MULT_W-1:0];
      end
      if (sel[`PCS_SEL_PRESCALE]) begin
        pre_stage_d = pwdata[`PCS_PRE_W-1:0];
      end
      if (sel[`PCS_SEL_SOURCE]) begin
        src_stage_d = pwdata[`PCS_FLAG_BIT];
      end
      if (sel[`PCS_SEL_ENABLE]) begin
        enable_d = pwdata[`PCS_FLAG_BIT];
      end
      if (sel[`PCS_SEL_IRQ_MASK]) begin
        mask_d = pwdata[`PCS_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Loop sequencing and applied configuration
  // ----------------------------------------------------------------
  // The state drops to OFF one cycle after a disable, so the lock flag
  // clears at once and never waits for the pin to fall.
  always @* begin
    state_d    = state_q;
    mult_act_d = mult_act_q;
    pre_act_d  = pre_act_q;
    src_act_d  = src_act_q;
    div_act_d  = div_act_q;
    if (enable_rise) begin
      mult_act_d = mult_stage_q;
      pre_act_d  = pre_stage_q;
      src_act_d  = src_stage_q;
      div_act_d  = div_decode(pre_stage_q);
    end
    case (state_q)
      ST_OFF: begin
        if (enable_rise) begin
          state_d = ST_APPLY;
        end
      end
      ST_APPLY: begin
        state_d = enable_q ? ST_WAIT : ST_OFF;
      end
      ST_WAIT: begin
        if (!enable_q) begin
          state_d = ST_OFF;
        end else if (lock_filt_q) begin
          state_d = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (!enable_q) begin
          state_d = ST_OFF;
        end else if (!lock_filt_q) begin
          state_d = ST_WAIT;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    // A stale lock from a disabled loop is reported for at most one cycle after the disable
    lock_flag_d = (state_d == ST_LOCK);
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  wire [`PCS_IRQ_W-1:0] events;
  assign events[`PCS_IRQ_APPLIED] = (state_q == ST_APPLY);
  assign events[`PCS_IRQ_LOCKED]  = (state_q == ST_WAIT) &&
                                    (state_d == ST_LOCK);
  // A loss caused by disabling raises nothing: software asked for it
  assign events[`PCS_IRQ_LOST]    = (state_q == ST_LOCK) &&
                                    (state_d == ST_WAIT);

  always @* begin
    stat_d = stat_q;
    // Only bits returned by this read are cleared; new events win
    if (stat_clr) begin
      stat_d = stat_d & ~stat_rd_q;
    end
    stat_d = stat_d | events;
    irq_d  = |(stat_d & mask_d);
  end

  // ----------------------------------------------------------------
  // Flops
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Staged and applied copies share reset values, so a first enable
      // with no writes leaves the loop outputs unchanged
      prdata_q     <= 32'h0000_0000;
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
      stat_rd_q    <= {`PCS_IRQ_W{1'b0}};
      mult_stage_q <= `PCS_MULT_RST;
      pre_stage_q  <= `PCS_PRE_RST;
      src_stage_q  <= `PCS_SRC_RST;
      mult_act_q   <= `PCS_MULT_RST;
      pre_act_q    <= `PCS_PRE_RST;
      src_act_q    <= `PCS_SRC_RST;
      div_act_q    <= `PCS_DIV_RST;
      enable_q     <= 1'b0;
      state_q      <= ST_OFF;
      lock_flag_q  <= 1'b0;
      lock_filt_q  <= 1'b0;
      stat_q       <= {`PCS_IRQ_W{1'b0}};
      mask_q       <= {`PCS_IRQ_W{1'b0}};
      irq_q        <= 1'b0;
    end else begin
      prdata_q     <= prdata_d;
      pready_q     <= pready_d;
      pslverr_q    <= pslverr_d;
      stat_rd_q    <= stat_rd_d;
      mult_stage_q <= mult_stage_d;
      pre_stage_q  <= pre_stage_d;
      src_stage_q  <= src_stage_d;
      mult_act_q   <= mult_act_d;
      pre_act_q    <= pre_act_d;
      src_act_q    <= src_act_d;
      div_act_q    <= div_act_d;
      enable_q     <= enable_d;
      state_q      <= state_d;
      lock_flag_q  <= lock_flag_d;
      lock_filt_q  <= lock_filt_d;
      stat_q       <= stat_d;
      mask_q       <= mask_d;
      irq_q        <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  // Applied values stay on the outputs while the loop is off; only
  // loop_run tells the analog side to stop.
  assign loop_run                 = enable_q;
  assign loop_multiplier          = mult_act_q;
  assign loop_prescale            = pre_act_q;
  assign loop_divide_onehot       = div_act_q;
  assign active_source_select_bit = src_act_q;
  assign irq                      = irq_q;

endmodule // pcs_top

`default_nettype wire

// File: pcs_monitor.sv
// Checker for the loop configuration block, bound to pcs_top.
// Assumes one clock pclk and zero-wait APB answers.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.vh"

module pcs_monitor (
  // APB slave
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`PCS_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Analog loop
  input wire logic                   loop_lock_pin,
  input wire logic                   loop_run,
  input wire logic [`PCS_MULT_W-1:0] loop_multiplier,
  input wire logic [`PCS_PRE_W-1:0]  loop_prescale,
  input wire logic [`PCS_DIV_W-1:0]  loop_divide_onehot,
  // Routing and interrupt
  input wire logic                   active_source_select_bit,
  input wire logic                   irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire logic setup = psel && !penable;
  wire logic done  = psel && penable && pready;
  wire logic en_hit = paddr == {`PCS_IDX_ENABLE, 2'b00};
  wire logic lk_hit = paddr == {`PCS_IDX_LOCK, 2'b00};

  AST_RESET_VALUES: assert property ($rose(presetn) |->
    loop_multiplier == `PCS_MULT_RST && loop_prescale == `PCS_PRE_RST
    && active_source_select_bit == `PCS_SRC_RST && !loop_run)
    else $error("applied state wrong after reset");
  AST_MULT_STAGED: assert property ($changed(loop_multiplier) |->
    $rose(loop_run)) else $error("multiplier changed without enable rise");
  AST_PRE_STAGED: assert property ($changed(loop_prescale) |->
    $rose(loop_run)) else $error("prescaler changed without enable rise");
  AST_SRC_STAGED: assert property ($changed(active_source_select_bit) |->
    $rose(loop_run)) else $error("source changed without enable rise");
  AST_ONEHOT: assert property (loop_divide_onehot ==
    (4'h1 << loop_prescale)) else $error("divide ratio does not match code");
  AST_APPLY: assert property (done && pwrite && en_hit && pwdata[0]
    && !loop_run |=> loop_run) else $error("enable write did not start loop");
  AST_DISABLE: assert property (done && pwrite && en_hit && !pwdata[0]
    |=> !loop_run) else $error("loop still running after disable");
  AST_LOCK_OFF: assert property (setup && !pwrite && lk_hit && !loop_run
    && !$past(loop_run) |=> pready && prdata[0] == 1'b0)
    else $error("lock flag set while loop disabled");
  AST_LOCK_RO: assert property (setup && pwrite && lk_hit |=>
    pready && pslverr) else $error("lock register write not refused");
  AST_READ_ANSWER: assert property (setup && !pwrite |=> pready
    ##1 !pready) else $error("read answer not one cycle");
endmodule // pcs_monitor

bind pcs_top pcs_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .loop_lock_pin(loop_lock_pin), .loop_run(loop_run),
  .loop_multiplier(loop_multiplier), .loop_prescale(loop_prescale),
  .loop_divide_onehot(loop_divide_onehot), .irq(irq),
  .active_source_select_bit(active_source_select_bit));
`default_nettype wire

// File: tb.sv
// Self-checking bench for pcs_top: APB master tasks, one task per test.
// Assumes the design answers every access within the wait bound.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.vh"

module tb;
  // ----
  // Signals
  // ----
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic                   lock_pin = 1'b0;
  logic [`PCS_ADDR_W-1:0] paddr = 18'h0_0000;
  logic [31:0]            pwdata = 32'h0000_0000;
  wire  [31:0]            prdata;
  wire                    pready, pslverr, loop_run, irq, src_bit;
  wire  [6:0]             mult;
  wire  [1:0]             pre;
  wire  [3:0]             onehot;
  int                     fails = 0;
  int                     tests_run = 0;

  always #2.5 pclk = ~pclk;

  pcs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loop_lock_pin(lock_pin), .loop_run(loop_run), .loop_multiplier(mult),
    .loop_prescale(pre), .loop_divide_onehot(onehot),
    .active_source_select_bit(src_bit), .irq(irq));

  // ----
  // Shared tasks
  // ----
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [31:0] wd, output logic [31:0] d,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready wait", 32'h0000_0001, {31'h0000_0000, pready});
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, wd, d, e);
    chk("write error", 32'h0000_0000, {31'h0000_0000, e});
  endtask

  task automatic rdc(input string what, input logic [15:0] idx,
                     input logic [31:0] x);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0000_0000, d, e);
    chk(what, x, d);
  endtask

  // Outputs are sampled mid-cycle, after the apply edge has landed
  task automatic outc(input logic r, input logic [6:0] m,
                      input logic [1:0] p, input logic s);
    @(negedge pclk);
    chk("applied", {17'h0_0000, r, m, p, 4'h1 << p, s},
        {17'h0_0000, loop_run, mult, pre, onehot, src_bit});
  endtask

  task automatic irqc(input logic x);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("irq", {31'h0000_0000, x}, {31'h0000_0000, irq});
  endtask

  // ----
  // Tests
  // ----
  task automatic t_reset;
    outc(1'b0, 7'h60, 2'h0, 1'b0);
    rdc("mult reset", `PCS_IDX_MULT, 32'h0000_0060);
    rdc("pre reset", `PCS_IDX_PRESCALE, 32'h0000_0000);
    rdc("src reset", `PCS_IDX_SOURCE, 32'h0000_0000);
    rdc("lock reset", `PCS_IDX_LOCK, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_stage;
    wr(`PCS_IDX_MULT, 32'hffff_ffaa);
    // Master clock taken as four times the loop input target: divide by 4
    wr(`PCS_IDX_PRESCALE, 32'hffff_fffe);
    wr(`PCS_IDX_SOURCE, 32'h0000_0001);
    rdc("mult staged", `PCS_IDX_MULT, 32'h0000_002a);
    rdc("pre staged", `PCS_IDX_PRESCALE, 32'h0000_0002);
    rdc("src staged", `PCS_IDX_SOURCE, 32'h0000_0001);
    outc(1'b0, 7'h60, 2'h0, 1'b0);
    wr(`PCS_IDX_ENABLE, 32'h0000_0001);
    outc(1'b1, 7'h2a, 2'h2, 1'b1);
    rdc("enable on", `PCS_IDX_ENABLE, 32'h0000_0001);
    wr(`PCS_IDX_MULT, 32'h0000_0011);
    wr(`PCS_IDX_ENABLE, 32'h0000_0001);
    outc(1'b1, 7'h2a, 2'h2, 1'b1);
    rdc("mult restaged", `PCS_IDX_MULT, 32'h0000_0011);
    wr(`PCS_IDX_ENABLE, 32'h0000_0000);
    outc(1'b0, 7'h2a, 2'h2, 1'b1);
    rdc("lock off", `PCS_IDX_LOCK, 32'h0000_0000);
    $display("test staging done");
  endtask

  task automatic t_codes;
    for (logic [2:0] c = 3'h0; c < 3'h4; c++) begin
      wr(`PCS_IDX_PRESCALE, {30'h0000_0000, c[1:0]});
      wr(`PCS_IDX_SOURCE, {31'h0000_0000, c[0]});
      wr(`PCS_IDX_ENABLE, 32'h0000_0001);
      outc(1'b1, 7'h11, c[1:0], c[0]);
      wr(`PCS_IDX_ENABLE, 32'h0000_0000);
    end
    $display("test codes done");
  endtask

  task automatic t_lock_irq;
    logic [31:0] d;
    logic e;
    wr(`PCS_IDX_IRQ_MASK, 32'h0000_0007);
    rdc("mask", `PCS_IDX_IRQ_MASK, 32'h0000_0007);
    wr(`PCS_IDX_ENABLE, 32'h0000_0001);
    irqc(1'b1);
    rdc("status applied", `PCS_IDX_IRQ_STAT, 32'h0000_0001);
    rdc("status cleared", `PCS_IDX_IRQ_STAT, 32'h0000_0000);
    irqc(1'b0);
    @(posedge pclk);
    lock_pin <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, `PCS_IDX_LOCK, 32'h0000_0000, d, e);
      if (d[0] === 1'b1) break;
    end
    chk("lock on", 32'h0000_0001, d);
    irqc(1'b1);
    rdc("status gained", `PCS_IDX_IRQ_STAT, 32'h0000_0002);
    irqc(1'b0);
    wr(`PCS_IDX_IRQ_MASK, 32'h0000_0000);
    @(posedge pclk);
    lock_pin <= 1'b0;
    irqc(1'b0);
    repeat (10) @(posedge pclk);
    rdc("lock lost", `PCS_IDX_LOCK, 32'h0000_0000);
    rdc("status lost", `PCS_IDX_IRQ_STAT, 32'h0000_0004);
    @(posedge pclk);
    lock_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    rdc("relock", `PCS_IDX_LOCK, 32'h0000_0001);
    wr(`PCS_IDX_ENABLE, 32'h0000_0000);
    rdc("lock when off", `PCS_IDX_LOCK, 32'h0000_0000);
    rdc("status off", `PCS_IDX_IRQ_STAT, 32'h0000_0002);
    $display("test lock and irq done");
  endtask

  task automatic t_errors;
    logic [31:0] d;
    logic e;
    apb(1'b0, 16'hf00f, 32'h0000_0000, d, e);
    chk("unmapped", 32'h0000_0001, {31'h0000_0000, e});
    apb(1'b1, `PCS_IDX_LOCK, 32'h0000_0001, d, e);
    chk("lock write", 32'h0000_0001, {31'h0000_0000, e});
    rdc("lock kept", `PCS_IDX_LOCK, 32'h0000_0000);
    wr(`PCS_IDX_IRQ_STAT, 32'h0000_0007);
    rdc("status write", `PCS_IDX_IRQ_STAT, 32'h0000_0000);
    $display("test errors done");
  endtask

  // Applied values differ from reset here, so the reset checks have teeth
  task automatic t_rereset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    outc(1'b0, 7'h60, 2'h0, 1'b0);
    rdc("mult re-reset", `PCS_IDX_MULT, 32'h0000_0060);
    rdc("pre re-reset", `PCS_IDX_PRESCALE, 32'h0000_0000);
    rdc("src re-reset", `PCS_IDX_SOURCE, 32'h0000_0000);
    $display("test mid-run reset done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fails++;
    $display("BAD watchdog expected finish seen timeout");
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_stage();
    t_codes();
    t_lock_irq();
    t_errors();
    t_rereset();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
